/* File: src/rwtc_debounce.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rwtc_defines.svh"

module rwtc_debounce #(
    parameter int unsigned P_BASE_CYCLES = `RWTC_DEB_BASE_CYCLES,
    parameter int unsigned P_MAX_CYCLES  = `RWTC_DEB_MAX_CYCLES
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    // comparator and code
    input  wire logic       i_raw,
    input  wire logic [3:0] i_code,
    // debounced fault
    output logic            o_fault
);

    rwtc_pkg::rwtc_deb_q_t       state_q;
    rwtc_pkg::rwtc_deb_q_t       state_d;
    logic [31:0]                 span;
    logic [`RWTC_DEB_CNT_W-1:0]  target;

    // ==========================================================
    // stable time selection
    always_comb begin
        span = 32'(P_BASE_CYCLES) << i_code;
        if ((i_code >= `RWTC_DEB_SAT_CODE) || (span > 32'(P_MAX_CYCLES))) begin
            span = 32'(P_MAX_CYCLES);
        end
        target = span[`RWTC_DEB_CNT_W-1:0];
    end

    // ==========================================================
    // stability filter
    always_comb begin
        state_d = state_q;
        case (state_q.st)
            rwtc_pkg::RWTC_DEB_IDLE: begin
                state_d.fault = 1'b0;
                if (i_raw) begin
                    if (target <= `RWTC_DEB_CNT_W'(1)) begin
                        state_d.st    = rwtc_pkg::RWTC_DEB_FAULT;
                        state_d.fault = 1'b1;
                    end else begin
                        state_d.st    = rwtc_pkg::RWTC_DEB_WAIT;
                        state_d.count = `RWTC_DEB_CNT_W'(1);
                    end
                end
            end
            rwtc_pkg::RWTC_DEB_WAIT: begin
                if (!i_raw) begin
                    state_d.st = rwtc_pkg::RWTC_DEB_IDLE;
                end else if (state_q.count >= target - `RWTC_DEB_CNT_W'(1)) begin
                    state_d.st    = rwtc_pkg::RWTC_DEB_FAULT;
                    state_d.fault = 1'b1;
                end else begin
                    state_d.count = state_q.count + `RWTC_DEB_CNT_W'(1);
                end
            end
            rwtc_pkg::RWTC_DEB_FAULT: begin
                if (!i_raw) begin
                    state_d.st    = rwtc_pkg::RWTC_DEB_IDLE;
                    state_d.fault = 1'b0;
                end
            end
            default: begin
                state_d.st    = rwtc_pkg::RWTC_DEB_IDLE;
                state_d.fault = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q.st    <= rwtc_pkg::RWTC_DEB_IDLE;
            state_q.count <= '0;
            state_q.fault <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_fault = state_q.fault;

endmodule : rwtc_debounce
`default_nettype wire

/* File: src/rwtc_defines.svh */
`ifndef RWTC_DEFINES_SVH
`define RWTC_DEFINES_SVH

// ==========================================================
// register offsets
`define RWTC_OFS_CUTOFF         8'h65
`define RWTC_OFS_FAST_UNDER     8'h70
`define RWTC_OFS_FAST_OVER      8'h71
`define RWTC_OFS_SLOW_UNDER     8'h72
`define RWTC_OFS_SLOW_OVER      8'h73
`define RWTC_OFS_DEBOUNCE       8'h74

// ==========================================================
// reset values
`define RWTC_RST_CUTOFF         8'h04
`define RWTC_RST_UNDER          8'h00
`define RWTC_RST_OVER           8'hFF
`define RWTC_RST_DEBOUNCE       8'h00

// ==========================================================
// field positions
`define RWTC_CUTOFF_MSB         2
`define RWTC_CUTOFF_LSB         0
`define RWTC_OVER_DEB_MSB       7
`define RWTC_OVER_DEB_LSB       4
`define RWTC_UNDER_DEB_MSB      3
`define RWTC_UNDER_DEB_LSB      0

// ==========================================================
// cutoff codes and corners in hz
`define RWTC_CUT_250            3'h2
`define RWTC_CUT_500            3'h3
`define RWTC_CUT_1K             3'h4
`define RWTC_CUT_2K             3'h5
`define RWTC_CUT_4K             3'h6
`define RWTC_HZ_250             13'h00FA
`define RWTC_HZ_500             13'h01F4
`define RWTC_HZ_1K              13'h03E8
`define RWTC_HZ_2K              13'h07D0
`define RWTC_HZ_4K              13'h0FA0

// ==========================================================
// threshold scaling in millivolts
`define RWTC_SCALE1_BASE_MV     13'h00C8
`define RWTC_SCALE1_STEP_MV     13'h0005
`define RWTC_SCALE4_BASE_MV     13'h0320
`define RWTC_SCALE4_STEP_MV     13'h0014

// ==========================================================
// debounce timing
`define RWTC_CLK_PERIOD_NS      4
`define RWTC_DEB_BASE_TIME_NS   100
`define RWTC_DEB_MAX_TIME_NS    102400
`define RWTC_DEB_BASE_CYCLES    ((`RWTC_DEB_BASE_TIME_NS + `RWTC_CLK_PERIOD_NS - 1) / `RWTC_CLK_PERIOD_NS)
`define RWTC_DEB_MAX_CYCLES     (`RWTC_DEB_MAX_TIME_NS / `RWTC_CLK_PERIOD_NS)
`define RWTC_DEB_SAT_CODE       4'hA
`define RWTC_DEB_CNT_W          16

`endif

/* File: src/rwtc_pkg.sv */
`default_nettype none
`include "rwtc_defines.svh"

package rwtc_pkg;

    // ==========================================================
    // debounce states
    typedef enum logic [2:0] {
        RWTC_DEB_IDLE  = 3'b001,
        RWTC_DEB_WAIT  = 3'b010,
        RWTC_DEB_FAULT = 3'b100
    } rwtc_deb_state_t;

    // ==========================================================
    // register bank
    typedef struct packed {
        logic [7:0] cutoff;
        logic [7:0] fast_under;
        logic [7:0] fast_over;
        logic [7:0] slow_under;
        logic [7:0] slow_over;
        logic [7:0] debounce;
    } rwtc_regs_t;

    typedef struct packed {
        logic [7:0] under;
        logic [7:0] over;
    } rwtc_window_t;

    typedef struct packed {
        logic under;
        logic over;
    } rwtc_cmp_t;

    typedef struct packed {
        rwtc_deb_state_t             st;
        logic [`RWTC_DEB_CNT_W-1:0]  count;
        logic                        fault;
    } rwtc_deb_q_t;

    typedef struct packed {
        rwtc_regs_t  regs;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [12:0] cutoff_hz;
        logic        cutoff_valid;
    } rwtc_top_q_t;

endpackage : rwtc_pkg
`default_nettype wire

/* File: src/rwtc_top.sv */
// Notes on behaviour
// - cutoff code picks slow path corner frequency
// - corner sets whole slow path 3 dB point
// - cutoff resets to 1 kHz code
// - 1x codes span 0.2 to 1.475 V
// - 4x codes span 0.8 to 5.9 V
// - scaling input sets threshold voltage meaning
// - fast under threshold at 0x70, reset 0x00
// - fast over threshold at 0x71, reset 0xFF
// - slow under threshold at 0x72, reset zero
// - slow over threshold at 0x73, reset ones
// - fast over fault waits stable high debounce
// - fast under fault waits stable low debounce
// - debounce time doubles, saturates at 102.4 us
`timescale 1ns/10ps
`default_nettype none
`include "rwtc_defines.svh"

module rwtc_top #(
    parameter int unsigned P_DEB_BASE_CYCLES = `RWTC_DEB_BASE_CYCLES,
    parameter int unsigned P_DEB_MAX_CYCLES  = `RWTC_DEB_MAX_CYCLES
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // register port from serial front end
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic [7:0]       o_reg_rdata,
    output logic             o_reg_rvalid,
    // monitored levels and scaling
    input  wire logic        i_range_scaling_select,
    input  wire logic [12:0] i_fast_path_mv,
    input  wire logic [12:0] i_slow_path_mv,
    // slow path filter setting
    output logic [2:0]       o_low_pass_stage_code,
    output logic             o_low_pass_stage_valid,
    output logic [12:0]      o_slow_path_corner_hz,
    // faults
    output logic             o_fast_path_under_fault,
    output logic             o_fast_path_over_fault,
    output logic             o_slow_path_under_fault,
    output logic             o_slow_path_over_fault
);

    rwtc_pkg::rwtc_top_q_t  state_q;
    rwtc_pkg::rwtc_top_q_t  state_d;
    rwtc_pkg::rwtc_window_t fast_window;
    rwtc_pkg::rwtc_window_t slow_window;
    rwtc_pkg::rwtc_cmp_t    fast_cmp;
    rwtc_pkg::rwtc_cmp_t    slow_cmp;
    logic [3:0]             over_debounce_code;
    logic [3:0]             under_debounce_code;
    logic [2:0]             cut_code;

    // ==========================================================
    // register write, read and cutoff decode
    always_comb begin
        state_d        = state_q;
        state_d.rvalid = i_reg_rd;
        if (i_reg_wr) begin
            case (i_reg_addr)
                `RWTC_OFS_CUTOFF: begin
                    state_d.regs.cutoff = i_reg_wdata;
                end
                `RWTC_OFS_FAST_UNDER: begin
                    state_d.regs.fast_under = i_reg_wdata;
                end
                `RWTC_OFS_FAST_OVER: begin
                    state_d.regs.fast_over = i_reg_wdata;
                end
                `RWTC_OFS_SLOW_UNDER: begin
                    state_d.regs.slow_under = i_reg_wdata;
                end
                `RWTC_OFS_SLOW_OVER: begin
                    state_d.regs.slow_over = i_reg_wdata;
                end
                `RWTC_OFS_DEBOUNCE: begin
                    state_d.regs.debounce = i_reg_wdata;
                end
                default: begin
                    state_d.regs = state_q.regs;
                end
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `RWTC_OFS_CUTOFF: begin
                    state_d.rdata = state_q.regs.cutoff;
                end
                `RWTC_OFS_FAST_UNDER: begin
                    state_d.rdata = state_q.regs.fast_under;
                end
                `RWTC_OFS_FAST_OVER: begin
                    state_d.rdata = state_q.regs.fast_over;
                end
                `RWTC_OFS_SLOW_UNDER: begin
                    state_d.rdata = state_q.regs.slow_under;
                end
                `RWTC_OFS_SLOW_OVER: begin
                    state_d.rdata = state_q.regs.slow_over;
                end
                `RWTC_OFS_DEBOUNCE: begin
                    state_d.rdata = state_q.regs.debounce;
                end
                default: begin
                    state_d.rdata = 8'h00;
                end
            endcase
        end
        // corner applies to the whole slow path response
        cut_code = state_d.regs.cutoff[`RWTC_CUTOFF_MSB:`RWTC_CUTOFF_LSB];
        state_d.cutoff_valid = 1'b1;
        case (cut_code)
            `RWTC_CUT_250: begin
                state_d.cutoff_hz = `RWTC_HZ_250;
            end
            `RWTC_CUT_500: begin
                state_d.cutoff_hz = `RWTC_HZ_500;
            end
            `RWTC_CUT_1K: begin
                state_d.cutoff_hz = `RWTC_HZ_1K;
            end
            `RWTC_CUT_2K: begin
                state_d.cutoff_hz = `RWTC_HZ_2K;
            end
            `RWTC_CUT_4K: begin
                state_d.cutoff_hz = `RWTC_HZ_4K;
            end
            default: begin
                state_d.cutoff_hz    = 13'h0000;
                state_d.cutoff_valid = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q.regs.cutoff     <= `RWTC_RST_CUTOFF;
            state_q.regs.fast_under <= `RWTC_RST_UNDER;
            state_q.regs.fast_over  <= `RWTC_RST_OVER;
            state_q.regs.slow_under <= `RWTC_RST_UNDER;
            state_q.regs.slow_over  <= `RWTC_RST_OVER;
            state_q.regs.debounce   <= `RWTC_RST_DEBOUNCE;
            state_q.rdata           <= 8'h00;
            state_q.rvalid          <= 1'b0;
            state_q.cutoff_hz       <= `RWTC_HZ_1K;
            state_q.cutoff_valid    <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // thresholds to comparators
    assign fast_window.under   = state_q.regs.fast_under;
    assign fast_window.over    = state_q.regs.fast_over;
    assign slow_window.under   = state_q.regs.slow_under;
    assign slow_window.over    = state_q.regs.slow_over;
    assign over_debounce_code  =
        state_q.regs.debounce[`RWTC_OVER_DEB_MSB:`RWTC_OVER_DEB_LSB];
    assign under_debounce_code =
        state_q.regs.debounce[`RWTC_UNDER_DEB_MSB:`RWTC_UNDER_DEB_LSB];

    rwtc_window_cmp u_fast_cmp (
        .i_clock    (i_clock),
        .i_srst     (i_srst),
        .i_scale_4x (i_range_scaling_select),
        .i_window   (fast_window),
        .i_level_mv (i_fast_path_mv),
        .o_cmp      (fast_cmp)
    );

    rwtc_window_cmp u_slow_cmp (
        .i_clock    (i_clock),
        .i_srst     (i_srst),
        .i_scale_4x (i_range_scaling_select),
        .i_window   (slow_window),
        .i_level_mv (i_slow_path_mv),
        .o_cmp      (slow_cmp)
    );

    // ==========================================================
    // fast path debounce
    rwtc_debounce #(
        .P_BASE_CYCLES (P_DEB_BASE_CYCLES),
        .P_MAX_CYCLES  (P_DEB_MAX_CYCLES)
    ) u_over_deb (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_raw   (fast_cmp.over),
        .i_code  (over_debounce_code),
        .o_fault (o_fast_path_over_fault)
    );

    rwtc_debounce #(
        .P_BASE_CYCLES (P_DEB_BASE_CYCLES),
        .P_MAX_CYCLES  (P_DEB_MAX_CYCLES)
    ) u_under_deb (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_raw   (fast_cmp.under),
        .i_code  (under_debounce_code),
        .o_fault (o_fast_path_under_fault)
    );

    // ==========================================================
    // outputs
    assign o_reg_rdata             = state_q.rdata;
    assign o_reg_rvalid            = state_q.rvalid;
    assign o_low_pass_stage_code   =
        state_q.regs.cutoff[`RWTC_CUTOFF_MSB:`RWTC_CUTOFF_LSB];
    assign o_low_pass_stage_valid  = state_q.cutoff_valid;
    assign o_slow_path_corner_hz   = state_q.cutoff_hz;
    assign o_slow_path_under_fault = slow_cmp.under;
    assign o_slow_path_over_fault  = slow_cmp.over;

endmodule : rwtc_top
`default_nettype wire

/* File: src/rwtc_window_cmp.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rwtc_defines.svh"

module rwtc_window_cmp (
    // clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_srst,
    // thresholds and level
    input  wire logic                 i_scale_4x,
    input  wire rwtc_pkg::rwtc_window_t i_window,
    input  wire logic [12:0]          i_level_mv,
    // compare result
    output var  rwtc_pkg::rwtc_cmp_t  o_cmp
);

    rwtc_pkg::rwtc_cmp_t state_q;
    rwtc_pkg::rwtc_cmp_t state_d;
    logic [12:0]         under_mv;
    logic [12:0]         over_mv;

    // ==========================================================
    // code to millivolts
    function automatic logic [12:0] to_mv(input logic [7:0] code,
                                          input logic       scale_4x);
        logic [12:0] wide;
        wide = {5'h00, code};
        if (scale_4x) begin
            to_mv = `RWTC_SCALE4_BASE_MV + `RWTC_SCALE4_STEP_MV * wide;
        end else begin
            to_mv = `RWTC_SCALE1_BASE_MV + `RWTC_SCALE1_STEP_MV * wide;
        end
    endfunction : to_mv

    // ==========================================================
    // window compare
    always_comb begin
        under_mv      = to_mv(i_window.under, i_scale_4x);
        over_mv       = to_mv(i_window.over, i_scale_4x);
        state_d       = state_q;
        state_d.under = (i_level_mv < under_mv);
        state_d.over  = (i_level_mv > over_mv);
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_cmp = state_q;

endmodule : rwtc_window_cmp
`default_nettype wire

/* File: testbench/rwtc_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module rwtc_chk #(
    parameter int unsigned P_DEB_BASE_CYCLES = 25,
    parameter int unsigned P_DEB_MAX_CYCLES  = 25600
) (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_srst,
    // register port
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_reg_rvalid,
    // levels and scaling
    input wire logic        i_range_scaling_select,
    input wire logic [12:0] i_fast_path_mv,
    input wire logic [12:0] i_slow_path_mv,
    // filter setting
    input wire logic [2:0]  o_low_pass_stage_code,
    input wire logic        o_low_pass_stage_valid,
    input wire logic [12:0] o_slow_path_corner_hz,
    // faults
    input wire logic        o_fast_path_under_fault,
    input wire logic        o_fast_path_over_fault,
    input wire logic        o_slow_path_under_fault,
    input wire logic        o_slow_path_over_fault
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // ==========================================================
    // shadow registers and run counters
    logic [7:0]  cut_q, fu_q, fo_q, su_q, so_q, db_q, rd_exp;
    logic [15:0] ov_run_q, uv_run_q;
    logic        fov, fuv, suv, sov;

    function automatic logic [12:0] mv(input logic s, input logic [7:0] c);
        return s ? 13'h0320 + 13'(c) * 13'h0014
                 : 13'h00C8 + 13'(c) * 13'h0005;
    endfunction : mv

    function automatic int unsigned tgt(input logic [3:0] c);
        int unsigned t;
        t = P_DEB_BASE_CYCLES << c;
        return (t > P_DEB_MAX_CYCLES) ? P_DEB_MAX_CYCLES : t;
    endfunction : tgt

    assign fov = i_fast_path_mv > mv(i_range_scaling_select, fo_q);
    assign fuv = i_fast_path_mv < mv(i_range_scaling_select, fu_q);
    assign suv = i_slow_path_mv < mv(i_range_scaling_select, su_q);
    assign sov = i_slow_path_mv > mv(i_range_scaling_select, so_q);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            {cut_q, fu_q, fo_q, su_q, so_q, db_q} <= 48'h0400_FF00_FF00;
            ov_run_q <= 16'h0000;
            uv_run_q <= 16'h0000;
        end else begin
            ov_run_q <= fov ? ov_run_q + 16'(ov_run_q != 16'hFFFF) : 16'h0;
            uv_run_q <= fuv ? uv_run_q + 16'(uv_run_q != 16'hFFFF) : 16'h0;
            if (i_reg_wr) begin
                case (i_reg_addr)
                    8'h65: cut_q <= i_reg_wdata;
                    8'h70: fu_q <= i_reg_wdata;
                    8'h71: fo_q <= i_reg_wdata;
                    8'h72: su_q <= i_reg_wdata;
                    8'h73: so_q <= i_reg_wdata;
                    8'h74: db_q <= i_reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        case (i_reg_addr)
            8'h65: rd_exp = cut_q;
            8'h70: rd_exp = fu_q;
            8'h71: rd_exp = fo_q;
            8'h72: rd_exp = su_q;
            8'h73: rd_exp = so_q;
            8'h74: rd_exp = db_q;
            default: rd_exp = 8'h00;
        endcase
    end

    // ==========================================================
    // properties
    property p_read;
        i_reg_rd |=> o_reg_rvalid && o_reg_rdata == $past(rd_exp);
    endproperty
    a_read: assert property (p_read)
        else $error("read data differs from register");
    property p_cut;
        o_low_pass_stage_code == cut_q[2:0] && o_low_pass_stage_valid
            == (cut_q[2:0] inside {[3'h2:3'h6]});
    endproperty
    a_cut: assert property (p_cut)
        else $error("cutoff code or valid wrong");
    property p_corner;
        o_slow_path_corner_hz == (o_low_pass_stage_valid ?
            13'h00FA << (o_low_pass_stage_code - 3'h2) : 13'h0000);
    endproperty
    a_corner: assert property (p_corner)
        else $error("corner frequency wrong");
    property p_slow_uv;
        !$past(i_srst) |-> o_slow_path_under_fault == $past(suv);
    endproperty
    a_slow_uv: assert property (p_slow_uv)
        else $error("slow under fault wrong");
    property p_slow_ov;
        !$past(i_srst) |-> o_slow_path_over_fault == $past(sov);
    endproperty
    a_slow_ov: assert property (p_slow_ov)
        else $error("slow over fault wrong");
    property p_fast_ov;
        $rose(o_fast_path_over_fault) |-> ov_run_q > tgt(db_q[7:4]);
    endproperty
    a_fast_ov: assert property (p_fast_ov)
        else $error("fast over fault too early");
    property p_fast_uv;
        $rose(o_fast_path_under_fault) |-> uv_run_q > tgt(db_q[3:0]);
    endproperty
    a_fast_uv: assert property (p_fast_uv)
        else $error("fast under fault too early");
    property p_fast_rel;
        !fov |-> ##2 !o_fast_path_over_fault;
    endproperty
    a_fast_rel: assert property (p_fast_rel)
        else $error("fast over fault not released");
endmodule : rwtc_chk
`default_nettype wire

/* File: testbench/rwtc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host side of the byte register port
module rwtc_host_model (
    // clock
    input  wire logic       i_clock,
    // register port
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    input  wire logic [7:0] i_reg_rdata,
    input  wire logic       i_reg_rvalid
);
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
    end

    // one write strobe, lines scrambled after
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_reg_wr    = 1'b1;
        o_reg_addr  = a;
        o_reg_wdata = d;
        @(negedge i_clock);
        o_reg_wr    = 1'b0;
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
    endtask : wr_reg

    // one read strobe, returns {rvalid, rdata}
    task automatic rd_reg(input logic [7:0] a, output logic [8:0] vd);
        @(negedge i_clock);
        o_reg_rd   = 1'b1;
        o_reg_addr = a;
        @(negedge i_clock);
        vd         = {i_reg_rvalid, i_reg_rdata};
        o_reg_rd   = 1'b0;
        o_reg_addr = ~a;
    endtask : rd_reg
endmodule : rwtc_host_model
`default_nettype wire

/* File: testbench/rwtc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module rwtc_top_tb;
    logic        clock, srst, scale, wr, rd, rvalid, valid;
    logic        f_uv, f_ov, s_uv, s_ov;
    logic [7:0]  addr, wdata, rdata;
    logic [12:0] fast_mv, slow_mv, corner;
    logic [2:0]  code;
    logic [8:0]  vd;
    int          mismatches, n_compared;
    logic [7:0]  adr [7] = '{8'h65, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h66};
    logic [7:0]  rst [7] = '{8'h04, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};

    rwtc_top #(.P_DEB_BASE_CYCLES(2), .P_DEB_MAX_CYCLES(64)) i_rwtc_top (
        .i_clock(clock), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_range_scaling_select(scale),
        .i_fast_path_mv(fast_mv), .i_slow_path_mv(slow_mv),
        .o_low_pass_stage_code(code), .o_low_pass_stage_valid(valid),
        .o_slow_path_corner_hz(corner), .o_fast_path_under_fault(f_uv),
        .o_fast_path_over_fault(f_ov), .o_slow_path_under_fault(s_uv),
        .o_slow_path_over_fault(s_ov));
    rwtc_host_model i_rwtc_host_model (
        .i_clock(clock), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

    initial clock = 1'b0;
    always #2 clock = ~clock;

    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic restore();
        for (int k = 0; k < 6; k++) i_rwtc_host_model.wr_reg(adr[k], rst[k]);
    endtask : restore

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk({code, valid}, {3'h4, 1'b1});
        chk(corner, 13'h03E8);
        for (int k = 0; k < 7; k++) begin
            i_rwtc_host_model.rd_reg(adr[k], vd);
            chk(vd, {1'b1, rst[k]});
        end
        $display("test reset values done");
    endtask : t_reset

    task automatic t_rw();
        for (int k = 0; k < 7; k++) begin
            i_rwtc_host_model.wr_reg(adr[k], 8'h5A ^ 8'(k));
            i_rwtc_host_model.rd_reg(adr[k], vd);
            chk(vd, {1'b1, k < 6 ? 8'h5A ^ 8'(k) : 8'h00});
        end
        restore();
        $display("test write read done");
    endtask : t_rw

    task automatic t_cutoff();
        logic [12:0] hz [8] = '{13'h0000, 13'h0000, 13'h00FA, 13'h01F4,
                                13'h03E8, 13'h07D0, 13'h0FA0, 13'h0000};
        for (int c = 0; c < 8; c++) begin
            i_rwtc_host_model.wr_reg(8'h65, 8'(c));
            chk({code, valid}, {3'(c), 1'(c >= 2 && c <= 6)});
            chk(corner, hz[c]);
        end
        restore();
        $display("test cutoff done");
    endtask : t_cutoff

    task automatic t_slow();
        logic [12:0] lv [6] = '{13'h0207, 13'h0208, 13'h0209, 13'h081F,
                                13'h0821, 13'h03E8};
        logic [1:0]  ex [6] = '{2'b10, 2'b00, 2'b01, 2'b10, 2'b01, 2'b10};
        i_rwtc_host_model.wr_reg(8'h72, 8'h40);
        i_rwtc_host_model.wr_reg(8'h73, 8'h40);
        for (int k = 0; k < 6; k++) begin
            scale   = 1'(k > 2);
            slow_mv = lv[k];
            @(negedge clock);
            chk({s_uv, s_ov}, ex[k]);
        end
        scale = 1'b0;
        restore();
        $display("test slow window done");
    endtask : t_slow

    task automatic t_fast(input logic ov, input logic [3:0] c, input int t);
        i_rwtc_host_model.wr_reg(8'h74, ov ? {c, 4'h0} : {4'h0, c});
        i_rwtc_host_model.wr_reg(ov ? 8'h71 : 8'h70, 8'h40);
        fast_mv = ov ? 13'h0209 : 13'h0207;
        repeat (t) @(negedge clock);
        chk(ov ? f_ov : f_uv, 1'b0);
        @(negedge clock);
        chk(ov ? f_ov : f_uv, 1'b1);
        fast_mv = 13'h0208;
        repeat (2) @(negedge clock);
        chk(ov ? f_ov : f_uv, 1'b0);
        restore();
        $display("test fast debounce done");
    endtask : t_fast

    // ==========================================================
    // main sequence and watchdog
    initial begin
        srst    = 1'b1;
        scale   = 1'b0;
        fast_mv = 13'h03E8;
        slow_mv = 13'h03E8;
        repeat (20) @(negedge clock);
        srst = 1'b0;
        t_reset();
        t_rw();
        t_cutoff();
        t_slow();
        t_fast(1'b1, 4'h3, 16);
        t_fast(1'b1, 4'hF, 64);
        t_fast(1'b0, 4'h2, 8);
        t_fast(1'b0, 4'hA, 64);
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : rwtc_top_tb

bind rwtc_top rwtc_chk #(.P_DEB_BASE_CYCLES(P_DEB_BASE_CYCLES),
    .P_DEB_MAX_CYCLES(P_DEB_MAX_CYCLES)) i_rwtc_chk (
    .i_clock(i_clock), .i_srst(i_srst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_range_scaling_select(i_range_scaling_select),
    .i_fast_path_mv(i_fast_path_mv), .i_slow_path_mv(i_slow_path_mv),
    .o_low_pass_stage_code(o_low_pass_stage_code),
    .o_low_pass_stage_valid(o_low_pass_stage_valid),
    .o_slow_path_corner_hz(o_slow_path_corner_hz),
    .o_fast_path_under_fault(o_fast_path_under_fault),
    .o_fast_path_over_fault(o_fast_path_over_fault),
    .o_slow_path_under_fault(o_slow_path_under_fault),
    .o_slow_path_over_fault(o_slow_path_over_fault));
`default_nettype wire
